/* core/edp_pkg.sv */
// constants, carrier types and shared functions of the energy detect block
package edp_pkg;

	// ****************************************
	// register map and field layout
	// ****************************************
	localparam logic [4:0] EDP_CTRL_ADDR      = 5'h1D;
	localparam int         EDP_BIT_ENABLE     = 15;
	localparam int         EDP_BIT_AUTO_UP    = 14;
	localparam int         EDP_BIT_AUTO_DOWN  = 13;
	localparam int         EDP_BIT_MANUAL     = 12;
	localparam int         EDP_BIT_BURST_DIS  = 11;
	localparam int         EDP_BIT_PWR_STATE  = 10;
	localparam int         EDP_BIT_ERR_MET    = 9;
	localparam int         EDP_BIT_DATA_MET   = 8;
	localparam int         EDP_ERR_THR_LSB    = 4;
	localparam int         EDP_DATA_THR_LSB   = 0;

	// ****************************************
	// values after reset
	// ****************************************
	localparam logic       EDP_RST_AUTO_UP    = 1'b1;
	localparam logic       EDP_RST_AUTO_DOWN  = 1'b1;
	localparam logic       EDP_RST_BURST_DIS  = 1'b0;
	localparam logic [3:0] EDP_RST_THRESHOLD  = 4'h1;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned EDP_CLK_HZ        = 100000000;
	localparam int unsigned EDP_QUIET_S       = 2;
	localparam int unsigned EDP_QUIET_CYCLES  = EDP_QUIET_S * EDP_CLK_HZ;
	localparam logic [2:0]  EDP_BURST_LEN     = 3'h4;
	localparam logic [2:0]  EDP_SINGLE_LEN    = 3'h1;
	localparam logic [3:0]  EDP_PULSE_GAP     = 4'h8;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic {
		EDP_PWR_DOWN,
		EDP_PWR_UP
	} edp_pwr_t;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} edp_reg_req_t;

	typedef struct packed {
		logic energy_present;
		logic data_event;
		logic error_event;
	} edp_line_t;

	// saturating step shared by both event counters
	function automatic logic [3:0] edp_sat_inc(input logic [3:0] v);
		return (v == 4'hF) ? v : v + 4'h1;
	endfunction : edp_sat_inc

endpackage : edp_pkg

/* core/edp_event_counter.sv */
// saturating event counter with threshold compare
`timescale 1ns/1ns
module edp_event_counter
	import edp_pkg::*;
(
	// clock and control
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       ce,
	input  wire logic       clear,
	// events and threshold
	input  wire logic       event_in,
	input  wire logic [3:0] threshold,
	// results
	output logic [3:0]      count,
	output logic            met
);

	typedef struct packed {
		logic [3:0] count;
		logic       met;
	} edp_cnt_state_t;

	edp_cnt_state_t s;
	edp_cnt_state_t n;

	// ****************************************
	// count and compare
	// ****************************************
	// saturates so a long burst of noise cannot wrap below the threshold
	always_comb begin
		n = s;
		if (clear) begin
			n.count = 4'h0;
		end else if (event_in) begin
			n.count = edp_sat_inc(s.count);
		end
		n.met = !clear && (n.count >= threshold);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign count = s.count;
	assign met   = s.met;

endmodule : edp_event_counter

/* core/edp_pulse_burst.sv */
// detect pulse sender: a burst or a single pulse per start
`timescale 1ns/1ns
module edp_pulse_burst
	import edp_pkg::*;
(
	// clock and control
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic start,
	input  wire logic single,
	// pulse out
	output logic      pulse,
	output logic      busy
);

	typedef struct packed {
		logic [2:0] remaining;
		logic [3:0] gap;
		logic       pulse;
	} edp_burst_state_t;

	edp_burst_state_t s;
	edp_burst_state_t n;

	// ****************************************
	// pulse sequencing
	// ****************************************
	// a start while busy is dropped; the running burst finishes first
	always_comb begin
		n = s;
		n.pulse = 1'b0;
		if (start && (s.remaining == 3'h0)) begin
			n.remaining = single ? EDP_SINGLE_LEN : EDP_BURST_LEN;
			n.gap       = 4'h0;
		end else if (s.remaining != 3'h0 && s.gap == 4'h0) begin
			n.pulse     = 1'b1;
			n.remaining = s.remaining - 3'h1;
			n.gap       = EDP_PULSE_GAP;
		end else if (s.gap != 4'h0) begin
			n.gap = s.gap - 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign pulse = s.pulse;
	assign busy  = (s.remaining != 3'h0);

endmodule : edp_pulse_burst

/* core/edp_power_control.sv */
// energy detect power control for one transceiver port
`timescale 1ns/1ns
module edp_power_control
	import edp_pkg::*;
#(
	parameter int unsigned QUIET_CYCLES = EDP_QUIET_CYCLES
)
(
	// clock, reset, enable
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	// strap level for the enable bit
	input  wire logic         strap_energy_enable,
	// management register port
	input  wire edp_reg_req_t reg_req,
	output logic [15:0]       reg_rdata,
	output logic              reg_rvalid,
	// line energy sensing
	input  wire edp_line_t    line,
	// power and pulse outputs
	output logic              rx_path_power,
	output logic              sense_power_state,
	output logic              detect_pulse
);

	typedef struct packed {
		logic        strap_done;
		logic        energy_sense_enable;
		logic        auto_power_up_enable;
		logic        auto_power_down_enable;
		logic        manual_power_toggle;
		logic        pulse_burst_disable;
		edp_pwr_t    pwr;
		logic        error_threshold_reached;
		logic        data_threshold_reached;
		logic [3:0]  error_event_threshold;
		logic [3:0]  data_event_threshold;
		logic [27:0] quiet_cnt;
		logic [15:0] rdata;
		logic        rvalid;
		logic        rx_power;
	} edp_ctrl_state_t;

	edp_ctrl_state_t s;
	edp_ctrl_state_t n;

	logic        rd_hit;
	logic        wr_hit;
	logic        quiet_expire;
	logic        counter_clear;
	logic        burst_start;
	logic        burst_busy;
	logic        data_lvl;
	logic        err_lvl;
	logic [3:0]  data_count;
	logic [3:0]  err_count;
	logic [15:0] ctrl_word;

	// ****************************************
	// decode and read view
	// ****************************************
	assign rd_hit       = reg_req.rd && (reg_req.addr == EDP_CTRL_ADDR);
	assign wr_hit       = reg_req.wr && (reg_req.addr == EDP_CTRL_ADDR);
	assign quiet_expire = (s.quiet_cnt == 28'(QUIET_CYCLES - 1));
	assign ctrl_word    = {s.energy_sense_enable, s.auto_power_up_enable,
		s.auto_power_down_enable, s.manual_power_toggle,
		s.pulse_burst_disable, (s.pwr == EDP_PWR_UP),
		s.error_threshold_reached, s.data_threshold_reached,
		s.error_event_threshold, s.data_event_threshold};

	// ****************************************
	// event counters and pulse sender
	// ****************************************
	edp_event_counter u_data_cnt (
		.clk       (clk),
		.resetn    (resetn),
		.ce        (ce),
		.clear     (counter_clear),
		.event_in  (line.data_event),
		.threshold (s.data_event_threshold),
		.count     (data_count),
		.met       (data_lvl)
	);

	edp_event_counter u_err_cnt (
		.clk       (clk),
		.resetn    (resetn),
		.ce        (ce),
		.clear     (counter_clear),
		.event_in  (line.error_event),
		.threshold (s.error_event_threshold),
		.count     (err_count),
		.met       (err_lvl)
	);

	edp_pulse_burst u_burst (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.start  (burst_start),
		.single (s.pulse_burst_disable),
		.pulse  (detect_pulse),
		.busy   (burst_busy)
	);

	// ****************************************
	// control, flags and power state
	// ****************************************
	// flags set and power moves only while enabled, flags held clear while off; the strap is caught once,
	// on the first clocked cycle after reset release
	always_comb begin
		n = s;
		counter_clear = 1'b0;
		burst_start   = 1'b0;
		if (!s.strap_done) begin
			n.strap_done          = 1'b1;
			n.energy_sense_enable = strap_energy_enable;
		end
		// quiet timer, restarted by every data event
		if (!s.energy_sense_enable || line.data_event || quiet_expire) begin
			n.quiet_cnt = 28'h0;
		end else begin
			n.quiet_cnt = s.quiet_cnt + 28'h1;
		end
		// read view; clear-on-read comes before the set so a set wins
		n.rvalid = reg_req.rd;
		n.rdata  = rd_hit ? ctrl_word : 16'h0000;
		if (rd_hit) begin
			n.error_threshold_reached = 1'b0;
			n.data_threshold_reached  = 1'b0;
		end
		if (s.energy_sense_enable) begin
			if (err_lvl) begin
				n.error_threshold_reached = 1'b1;
			end
			if (data_lvl) begin
				n.data_threshold_reached = 1'b1;
			end
		end else begin
			n.error_threshold_reached = 1'b0;
			n.data_threshold_reached  = 1'b0;
		end
		// power sequencing; a pending manual toggle overrides automation
		n.manual_power_toggle = 1'b0;
		if (s.energy_sense_enable) begin
			if (s.manual_power_toggle) begin
				n.pwr = (s.pwr == EDP_PWR_UP) ? EDP_PWR_DOWN : EDP_PWR_UP;
			end else if (s.pwr == EDP_PWR_DOWN && s.auto_power_up_enable
				&& data_lvl) begin
				n.pwr = EDP_PWR_UP;
			end else if (s.pwr == EDP_PWR_UP && s.auto_power_down_enable
				&& !line.energy_present) begin
				n.pwr = EDP_PWR_DOWN;
			end
		end
		burst_start = (s.pwr == EDP_PWR_DOWN) && (n.pwr == EDP_PWR_UP);
		// counters restart on every power change, on quiet, and when off
		counter_clear = !s.energy_sense_enable || quiet_expire
			|| (n.pwr != s.pwr);
		// register write
		if (wr_hit) begin
			n.energy_sense_enable    = reg_req.wdata[EDP_BIT_ENABLE];
			n.auto_power_up_enable   = reg_req.wdata[EDP_BIT_AUTO_UP];
			n.auto_power_down_enable = reg_req.wdata[EDP_BIT_AUTO_DOWN];
			n.manual_power_toggle    = reg_req.wdata[EDP_BIT_MANUAL];
			n.pulse_burst_disable    = reg_req.wdata[EDP_BIT_BURST_DIS];
			n.error_event_threshold  =
				reg_req.wdata[EDP_ERR_THR_LSB +: 4];
			n.data_event_threshold   =
				reg_req.wdata[EDP_DATA_THR_LSB +: 4];
		end
		// receive path stays on while sensing is off
		n.rx_power = !n.energy_sense_enable || (n.pwr == EDP_PWR_UP);
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			s                        <= '0;
			s.auto_power_up_enable   <= EDP_RST_AUTO_UP;
			s.auto_power_down_enable <= EDP_RST_AUTO_DOWN;
			s.pulse_burst_disable    <= EDP_RST_BURST_DIS;
			s.error_event_threshold  <= EDP_RST_THRESHOLD;
			s.data_event_threshold   <= EDP_RST_THRESHOLD;
			s.pwr                    <= EDP_PWR_DOWN;
			s.rx_power               <= 1'b1;
		end else if (ce) begin
			s <= n;
		end
	end

	assign reg_rdata         = s.rdata;
	assign reg_rvalid        = s.rvalid;
	assign rx_path_power     = s.rx_power;
	assign sense_power_state = (s.pwr == EDP_PWR_UP);

	// ****************************************
	// assertions
	// ****************************************
	property p_strap_load;
		@(posedge clk) disable iff (!resetn || !ce)
		!s.strap_done |=> (s.energy_sense_enable == $past(strap_energy_enable));
	endproperty
	a_strap_load: assert property (p_strap_load)
		else $error("enable bit did not take the strap");

	property p_auto_up;
		@(posedge clk) disable iff (!resetn || !ce)
		(s.energy_sense_enable && s.auto_power_up_enable && data_lvl
			&& s.pwr == EDP_PWR_DOWN && !s.manual_power_toggle)
			|=> (s.pwr == EDP_PWR_UP);
	endproperty
	a_auto_up: assert property (p_auto_up)
		else $error("no power up at data threshold");

	property p_auto_down;
		@(posedge clk) disable iff (!resetn || !ce)
		(s.energy_sense_enable && s.auto_power_down_enable
			&& !line.energy_present && s.pwr == EDP_PWR_UP
			&& !s.manual_power_toggle) |=> (s.pwr == EDP_PWR_DOWN);
	endproperty
	a_auto_down: assert property (p_auto_down)
		else $error("no power down without energy");

	property p_manual;
		@(posedge clk) disable iff (!resetn || !ce)
		(s.energy_sense_enable && s.manual_power_toggle && !wr_hit)
			|=> (s.pwr != $past(s.pwr)) && !s.manual_power_toggle;
	endproperty
	a_manual: assert property (p_manual)
		else $error("manual toggle did not flip and clear");

	property p_burst;
		@(posedge clk) disable iff (!resetn || !ce)
		(burst_start && !burst_busy && !s.pulse_burst_disable)
			|-> ##2 detect_pulse ##9 detect_pulse ##9 detect_pulse
			##9 detect_pulse;
	endproperty
	a_burst: assert property (p_burst)
		else $error("burst of four pulses missing");

	property p_single;
		@(posedge clk) disable iff (!resetn || !ce)
		(burst_start && !burst_busy && s.pulse_burst_disable)
			|-> ##2 detect_pulse ##1 (!detect_pulse) [*8];
	endproperty
	a_single: assert property (p_single)
		else $error("single pulse mode sent more than one");

	property p_readback;
		@(posedge clk) disable iff (!resetn || !ce)
		rd_hit |=> reg_rvalid
			&& (reg_rdata[EDP_BIT_PWR_STATE] == $past(sense_power_state));
	endproperty
	a_readback: assert property (p_readback)
		else $error("power state readback wrong");

	property p_err_clear;
		@(posedge clk) disable iff (!resetn || !ce)
		(rd_hit && !(err_lvl && s.energy_sense_enable))
			|=> !s.error_threshold_reached;
	endproperty
	a_err_clear: assert property (p_err_clear)
		else $error("error flag survived a read");

	property p_data_set;
		@(posedge clk) disable iff (!resetn || !ce)
		(s.energy_sense_enable && data_lvl) |=> s.data_threshold_reached;
	endproperty
	a_data_set: assert property (p_data_set)
		else $error("data flag not set at threshold");

	property p_thr_write;
		@(posedge clk) disable iff (!resetn || !ce)
		wr_hit |=> (s.error_event_threshold == $past(reg_req.wdata[7:4]))
			&& (s.data_event_threshold == $past(reg_req.wdata[3:0]));
	endproperty
	a_thr_write: assert property (p_thr_write)
		else $error("threshold fields not written");

	property p_quiet;
		@(posedge clk) disable iff (!resetn || !ce)
		(s.energy_sense_enable && quiet_expire)
			|=> (data_count == 4'h0) && (err_count == 4'h0)
			&& (s.quiet_cnt == 28'h0);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("counters not cleared after quiet time");

	property p_disabled;
		@(posedge clk) disable iff (!resetn || !ce)
		(!s.energy_sense_enable && s.strap_done) |=> $stable(s.pwr)
			&& !s.data_threshold_reached && !s.error_threshold_reached;
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("activity while energy sensing disabled");

	c_power_up: cover property (@(posedge clk) disable iff (!resetn)
		s.pwr == EDP_PWR_DOWN ##1 s.pwr == EDP_PWR_UP);
	c_power_down: cover property (@(posedge clk) disable iff (!resetn)
		s.pwr == EDP_PWR_UP ##1 s.pwr == EDP_PWR_DOWN);
	c_manual: cover property (@(posedge clk) disable iff (!resetn)
		s.manual_power_toggle && s.energy_sense_enable);
	c_quiet: cover property (@(posedge clk) disable iff (!resetn)
		quiet_expire && s.energy_sense_enable);

endmodule : edp_power_control

/* test/edp_link_partner.sv */
// behavioural far end of the line: energy level, events, pulse tally
`timescale 1ns/1ns
module edp_link_partner
	import edp_pkg::*;
(
	// clock
	input  wire logic clk,
	// line toward the block
	output edp_line_t line,
	// detect pulses coming back
	input  wire logic detect_pulse,
	output int        pulses
);
	// line starts quiet so nothing is counted before the bench asks
	initial begin
		line = '0;
		pulses = 0;
	end

	// tally of every detect pulse seen on the wire
	always @(posedge clk) begin
		if (detect_pulse) begin
			pulses <= pulses + 1;
		end
	end

	// energy is a level; held high while traffic is on the cable
	task automatic set_energy(input logic on);
		@(posedge clk);
		line.energy_present <= on;
	endtask : set_energy

	// n one-cycle events, gap + 1 idle cycles apart (0 = prompt, more = slow)
	task automatic send(input bit err, input int n, input int gap);
		repeat (n) begin
			@(posedge clk);
			if (err) begin
				line.error_event <= 1'b1;
			end else begin
				line.data_event <= 1'b1;
			end
			@(posedge clk);
			line.error_event <= 1'b0;
			line.data_event <= 1'b0;
			repeat (gap) @(posedge clk);
		end
	endtask : send
endmodule : edp_link_partner

/* test/testbench.sv */
// self-checking bench for the energy detect power control block
`timescale 1ns/1ns
`define CHK(a, e, m) num_checks++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %0t %s", $time, m); end
module testbench;
	import edp_pkg::*;

	// ****************************************
	// signals and instances
	// ****************************************
	localparam int QUIET = 64;
	typedef struct packed {
		logic [4:0]  a;
		logic [15:0] d;
		logic [15:0] e;
	} edp_row_t;
	logic         clk = 1'b0;
	logic         resetn = 1'b0;
	logic         ce = 1'b1;
	// sensing strapped on; the enable bit takes this level after reset
	logic         strap = 1'b1;
	edp_reg_req_t req = '0;
	logic [15:0]  rdata;
	logic         rvalid;
	edp_line_t    line;
	logic         rxp;
	logic         sps;
	logic         dp;
	int           pulses;
	int           base;
	int           fails = 0;
	int           num_checks = 0;
	int           cycles = 0;
	edp_row_t     rows[5] = '{'{5'h1D, 16'hE0A5, 16'hE0A5},
		'{5'h1D, 16'h67FF, 16'h60FF}, '{5'h1D, 16'h1000, 16'h0000},
		'{5'h1C, 16'hFFFF, 16'h0000}, '{5'h1D, 16'hE811, 16'hE811}};

	edp_power_control #(.QUIET_CYCLES(QUIET)) u_edp_power_control (
		.clk(clk), .resetn(resetn), .ce(ce), .strap_energy_enable(strap),
		.reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
		.line(line), .rx_path_power(rxp), .sense_power_state(sps),
		.detect_pulse(dp));
	edp_link_partner u_edp_link_partner (.clk(clk), .line(line),
		.detect_pulse(dp), .pulses(pulses));

	// ****************************************
	// clock, timeout and tasks
	// ****************************************
	always #5 clk = ~clk;

	// ceiling well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			$display("[ERR] %0t timeout", $time);
			end_of_test();
		end
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : reg_wr

	// read, then compare the word under a mask; answer stands one cycle
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] e,
		input logic [15:0] m, input string s);
		@(posedge clk);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		`CHK(rvalid, 1'b1, "no read answer")
		`CHK(rdata & m, e & m, s)
	endtask : rd_chk

	task automatic end_of_test;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		step(2);
		// register round trips; read-only bits and unmapped place
		foreach (rows[i]) begin
			reg_wr(rows[i].a, rows[i].d);
			rd_chk(rows[i].a, rows[i].e, 16'hFFFF, "row word");
		end
		$display("test table done");
		// second reset in mid-run brings back strap and defaults
		@(posedge clk);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		step(2);
		`CHK(rxp, 1'b0, "rx path on after strap")
		`CHK(sps, 1'b0, "state after reset")
		rd_chk(5'h1D, 16'hE011, 16'hFFFF, "reset word");
		$display("test reset done");
		// data threshold 3 reached on third event, then a burst of four
		reg_wr(5'h1D, 16'hE013);
		u_edp_link_partner.set_energy(1'b1);
		u_edp_link_partner.send(1'b0, 2, 3);
		step(4);
		`CHK(sps, 1'b0, "early power up")
		base = pulses;
		u_edp_link_partner.send(1'b0, 1, 0);
		step(40);
		`CHK(sps, 1'b1, "no power up")
		`CHK(pulses - base, 4, "burst length")
		rd_chk(5'h1D, 16'hE513, 16'hFFFF, "data flag");
		rd_chk(5'h1D, 16'hE413, 16'hFFFF, "flag not cleared");
		$display("test auto up done");
		// error threshold only raises its flag
		reg_wr(5'h1D, 16'hE023);
		u_edp_link_partner.send(1'b1, 2, 1);
		step(3);
		`CHK(sps, 1'b1, "error event acted")
		rd_chk(5'h1D, 16'hE623, 16'hFFFF, "error flag");
		// level stays met until the quiet wipe; the flag must outlive it
		step(QUIET);
		rd_chk(5'h1D, 16'hE623, 16'hFFFF, "flag lost");
		rd_chk(5'h1D, 16'hE423, 16'hFFFF, "error flag stuck");
		// loss of energy powers down
		u_edp_link_partner.set_energy(1'b0);
		step(3);
		`CHK(sps, 1'b0, "no power down")
		`CHK(rxp, 1'b0, "rx path still on")
		rd_chk(5'h1D, 16'hE023, 16'hFFFF, "state bit");
		$display("test error and down done");
		// manual toggle up with burst disabled, then down again
		u_edp_link_partner.set_energy(1'b1);
		base = pulses;
		reg_wr(5'h1D, 16'hF823);
		step(3);
		`CHK(sps, 1'b1, "manual up")
		step(30);
		`CHK(pulses - base, 1, "single pulse")
		rd_chk(5'h1D, 16'hEC23, 16'hFFFF, "toggle not cleared");
		reg_wr(5'h1D, 16'hF823);
		step(3);
		`CHK(sps, 1'b0, "manual down")
		$display("test manual done");
		// quiet spell wipes partial counts
		u_edp_link_partner.send(1'b0, 2, 1);
		step(QUIET + 16);
		u_edp_link_partner.send(1'b0, 1, 1);
		step(4);
		`CHK(sps, 1'b0, "count survived quiet")
		u_edp_link_partner.send(1'b0, 2, 1);
		step(4);
		`CHK(sps, 1'b1, "no up after quiet")
		$display("test quiet done");
		// disabled: no transitions, flags held clear, rx path on
		reg_wr(5'h1D, 16'h6023);
		u_edp_link_partner.set_energy(1'b0);
		u_edp_link_partner.send(1'b0, 5, 1);
		step(4);
		`CHK(sps, 1'b1, "moved while disabled")
		`CHK(rxp, 1'b1, "rx path off while disabled")
		rd_chk(5'h1D, 16'h6023, 16'hFBFF, "flags while disabled");
		$display("test disable done");
		// frozen clock enable: a write must not land
		@(posedge clk);
		ce <= 1'b0;
		reg_wr(5'h1D, 16'hE0F5);
		@(posedge clk);
		ce <= 1'b1;
		rd_chk(5'h1D, 16'h6023, 16'hFBFF, "write while frozen");
		`CHK(sps, 1'b1, "state moved while frozen")
		$display("test freeze done");
		end_of_test();
	end
endmodule : testbench
